// ===== pkg/dct_pkg.sv
// constants for the display clock and sync timing block
// assumes one 250 MHz base clock and a plain register port
package dct_pkg;
    // base clock and encoder pixel clock figures
    localparam int BASE_FREQ_KHZ = 250000;
    localparam int ENC_FREQ_KHZ  = 27000;
    localparam int ENC_TOL_PCT   = 10;
    localparam int PCT_FULL      = 100;
    localparam int FRAC_BITS     = 4;
    localparam int FRAC_STEPS    = 1 << FRAC_BITS;
    // widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int DIV_W   = 12;
    localparam int RATIO_W = 4;
    localparam int EDGE_W  = 8;
    localparam int CNT_W   = 12;
    localparam int ERR_W   = 14;
    localparam int POS_W   = 11;
    localparam int PIX_W   = 8;
    localparam int CTRL_W  = 8;
    localparam int LIM_W   = 16;
    // encoder divisor window in sixteenths of a base clock per unit ratio
    localparam int ENC_DIV_MIN = (FRAC_STEPS * BASE_FREQ_KHZ * PCT_FULL
        + ENC_FREQ_KHZ * (PCT_FULL + ENC_TOL_PCT) - 1)
        / (ENC_FREQ_KHZ * (PCT_FULL + ENC_TOL_PCT));
    localparam int ENC_DIV_MAX = (FRAC_STEPS * BASE_FREQ_KHZ * PCT_FULL)
        / (ENC_FREQ_KHZ * (PCT_FULL - ENC_TOL_PCT));
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DIV   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RATIO = 8'h08;
    localparam logic [ADDR_W-1:0] REG_EDGE  = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_HTIM  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_HACT  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_VTIM  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_VACT  = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_STAT  = 8'h20;
    // control bits and field positions
    localparam int CB_EN = 0, CB_ENC = 1, CB_HPOL = 2, CB_VPOL = 3;
    localparam int CB_DPOL = 4, CB_HHALF = 5, CB_VHALF = 6, CB_DHALF = 7;
    localparam int HI_LSB = 16;
    localparam int SB_FIELD = 28, SB_OK = 29, SB_RUN = 30;
    localparam int CI_HS = 0, CI_VS = 1, CI_DV = 2, NCTL = 3;
    // reset values
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 8'h00;
    localparam logic [DIV_W-1:0]   DIV_RST   = 12'h094;
    localparam logic [RATIO_W-1:0] RATIO_RST = 4'h1;
    localparam logic [EDGE_W-1:0]  RISE_RST  = 8'h00;
    localparam logic [EDGE_W-1:0]  FALL_RST  = 8'h04;
    localparam logic [CNT_W-1:0]   HTOT_RST  = 12'h35a;
    localparam logic [CNT_W-1:0]   HSW_RST   = 12'h001;
    localparam logic [CNT_W-1:0]   HST_RST   = 12'h08a;
    localparam logic [CNT_W-1:0]   HWD_RST   = 12'h2d0;
    localparam logic [CNT_W-1:0]   VTOT_RST  = 12'h20d;
    localparam logic [CNT_W-1:0]   VSW_RST   = 12'h003;
    localparam logic [CNT_W-1:0]   VST_RST   = 12'h016;
    localparam logic [CNT_W-1:0]   VHT_RST   = 12'h1e0;
endpackage

// ===== rtl/dct_display_timing.sv
// pixel clock divider, sync and data-valid generator for panel or encoder
// assumes clk_sys is the 250 MHz base clock and software on a plain port
// Functional notes
// - integer quotient gives every pixel period exactly that many base clocks
// - fractional quotient gives floor or floor+1 periods, exact mean
// - divisor is ratio times the base clocks per pixel period, in sixteenths
// - control edges sit on a half base clock grid
// - data bus changes only on whole base clock boundaries
// - each counter derives offset, period and edges from its settings
// - horizontal counter period is the total line length
// - fall point is half clock times ceil of twice fall over ratio
// - rise point is half clock times ceil of twice rise over ratio
// - clock low from rise point to fall point, high the rest
// - encoder mode moves one 8-bit component per pixel clock
// - encoder mode pixel clock is 27 MHz within ten percent
// - encoder mode syncs active low, data valid active high
// - encoder mode hsync low exactly one pixel at each row
// - encoder mode vsync low at least one pixel at each field
// - odd field vsync and hsync fall together, even field apart
// - encoder mode data moves only while hsync is high
// - pixel clock edges move in half base clock steps
// - data valid gates the bus, data invalid while it is off
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module dct_display_timing
    import dct_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [PIX_W-1:0]  pix_data,
    output logic                   pix_take,
    output logic      [1:0]        pclk_pair,
    output logic      [1:0]        hsync_pair,
    output logic      [1:0]        vsync_pair,
    output logic      [1:0]        dvalid_pair,
    output logic      [PIX_W-1:0]  data_bus
);
    logic [CTRL_W-1:0]  ctrl_q,  ctrl_d;
    logic [DIV_W-1:0]   div_q,   div_d;
    logic [RATIO_W-1:0] ratio_q, ratio_d;
    logic [EDGE_W-1:0]  rise_q,  rise_d;
    logic [EDGE_W-1:0]  fall_q,  fall_d;
    logic [CNT_W-1:0]   htot_q,  htot_d;
    logic [CNT_W-1:0]   hsw_q,   hsw_d;
    logic [CNT_W-1:0]   hst_q,   hst_d;
    logic [CNT_W-1:0]   hwd_q,   hwd_d;
    logic [CNT_W-1:0]   vtot_q,  vtot_d;
    logic [CNT_W-1:0]   vsw_q,   vsw_d;
    logic [CNT_W-1:0]   vst_q,   vst_d;
    logic [CNT_W-1:0]   vht_q,   vht_d;
    logic [DATA_W-1:0]  rdata_q, rdata_d;
    logic [ERR_W-1:0]   err_q,   err_d;
    logic [POS_W-1:0]   pos_q,   pos_d;
    logic [CNT_W-1:0]   hcnt_q,  hcnt_d;
    logic [CNT_W-1:0]   vcnt_q,  vcnt_d;
    logic               field_q, field_d;
    logic [1:0]         pclk_q,  pclk_d;
    logic [NCTL-1:0]    act_q,   act_d;
    logic [NCTL-1:0]    prev_q;
    logic [PIX_W-1:0]   data_q,  data_d;
    logic [ERR_W-1:0]   step;
    logic [ERR_W-1:0]   acc;
    logic               pstart;
    logic               enc;
    logic               run;
    logic               rate_ok;
    logic [LIM_W-1:0]   lim_lo;
    logic [LIM_W-1:0]   lim_hi;
    logic [POS_W-1:0]   h1;
    logic [POS_W-1:0]   rise_pt;
    logic [POS_W-1:0]   fall_pt;
    logic [NCTL-1:0]    act_on;
    logic [NCTL-1:0]    half;
    logic               in_h;
    logic               in_v;

    // mode, accumulator step and encoder rate window
    assign enc     = ctrl_q[CB_ENC];
    assign step    = ERR_W'({ratio_q, {FRAC_BITS{1'b0}}});
    assign acc     = err_q + step;
    assign pstart  = acc >= ERR_W'(div_q);
    assign lim_lo  = LIM_W'(ENC_DIV_MIN) * LIM_W'(ratio_q);
    assign lim_hi  = LIM_W'(ENC_DIV_MAX) * LIM_W'(ratio_q);
    assign rate_ok = (LIM_W'(div_q) >= lim_lo) && (LIM_W'(div_q) <= lim_hi);
    assign run     = ctrl_q[CB_EN] && (!enc || rate_ok);
    // half step positions scaled by ratio, so no divider is needed
    assign rise_pt = POS_W'({rise_q, 1'b0});
    assign fall_pt = POS_W'({fall_q, 1'b0});

    // register writes and read answers
    always_comb
    begin
        ctrl_d  = ctrl_q;
        div_d   = div_q;
        ratio_d = ratio_q;
        rise_d  = rise_q;
        fall_d  = fall_q;
        htot_d  = htot_q;
        hsw_d   = hsw_q;
        hst_d   = hst_q;
        hwd_d   = hwd_q;
        vtot_d  = vtot_q;
        vsw_d   = vsw_q;
        vst_d   = vst_q;
        vht_d   = vht_q;
        rdata_d = '0;
        if (reg_wr)
        begin
            case (reg_addr)
                REG_CTRL:  ctrl_d  = reg_wdata[CTRL_W-1:0];
                REG_DIV:   div_d   = reg_wdata[DIV_W-1:0];
                REG_RATIO: ratio_d = reg_wdata[RATIO_W-1:0];
                REG_EDGE:
                begin
                    rise_d = reg_wdata[EDGE_W-1:0];
                    fall_d = reg_wdata[HI_LSB +: EDGE_W];
                end
                REG_HTIM:
                begin
                    htot_d = reg_wdata[CNT_W-1:0];
                    hsw_d  = reg_wdata[HI_LSB +: CNT_W];
                end
                REG_HACT:
                begin
                    hst_d = reg_wdata[CNT_W-1:0];
                    hwd_d = reg_wdata[HI_LSB +: CNT_W];
                end
                REG_VTIM:
                begin
                    vtot_d = reg_wdata[CNT_W-1:0];
                    vsw_d  = reg_wdata[HI_LSB +: CNT_W];
                end
                REG_VACT:
                begin
                    vst_d = reg_wdata[CNT_W-1:0];
                    vht_d = reg_wdata[HI_LSB +: CNT_W];
                end
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL:  rdata_d[CTRL_W-1:0]  = ctrl_q;
                REG_DIV:   rdata_d[DIV_W-1:0]   = div_q;
                REG_RATIO: rdata_d[RATIO_W-1:0] = ratio_q;
                REG_EDGE:  rdata_d = {8'h00, fall_q, 8'h00, rise_q};
                REG_HTIM:  rdata_d = {4'h0, hsw_q, 4'h0, htot_q};
                REG_HACT:  rdata_d = {4'h0, hwd_q, 4'h0, hst_q};
                REG_VTIM:  rdata_d = {4'h0, vsw_q, 4'h0, vtot_q};
                REG_VACT:  rdata_d = {4'h0, vht_q, 4'h0, vst_q};
                REG_STAT:  rdata_d = {1'b0, run, rate_ok, field_q, vcnt_q, 4'h0, hcnt_q};
                default:   rdata_d = '0;
            endcase
        end
    end

    // register file storage
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q  <= CTRL_RST;
            div_q   <= DIV_RST;
            ratio_q <= RATIO_RST;
            rise_q  <= RISE_RST;
            fall_q  <= FALL_RST;
            htot_q  <= HTOT_RST;
            hsw_q   <= HSW_RST;
            hst_q   <= HST_RST;
            hwd_q   <= HWD_RST;
            vtot_q  <= VTOT_RST;
            vsw_q   <= VSW_RST;
            vst_q   <= VST_RST;
            vht_q   <= VHT_RST;
            rdata_q <= '0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            div_q   <= div_d;
            ratio_q <= ratio_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
            htot_q  <= htot_d;
            hsw_q   <= hsw_d;
            hst_q   <= hst_d;
            hwd_q   <= hwd_d;
            vtot_q  <= vtot_d;
            vsw_q   <= vsw_d;
            vst_q   <= vst_d;
            vht_q   <= vht_d;
            rdata_q <= rdata_d;
        end
    end

    // pixel period accumulator, line and frame counters, output levels
    always_comb
    begin
        err_d   = '0;
        pos_d   = '0;
        hcnt_d  = '0;
        vcnt_d  = '0;
        field_d = 1'b0;
        if (run && pstart)
        begin
            err_d = acc - ERR_W'(div_q);
            field_d = field_q;
            vcnt_d = vcnt_q;
            if ({1'b0, hcnt_q} + 1'b1 >= {1'b0, htot_q})
            begin
                if ({1'b0, vcnt_q} + 1'b1 >= {1'b0, vtot_q})
                begin
                    vcnt_d  = '0;
                    field_d = enc && !field_q;
                end
                else
                    vcnt_d = vcnt_q + 1'b1;
            end
            else
                hcnt_d = hcnt_q + 1'b1;
        end
        else if (run)
        begin
            err_d   = acc;
            pos_d   = pos_q + POS_W'({ratio_q, 1'b0});
            hcnt_d  = hcnt_q;
            vcnt_d  = vcnt_q;
            field_d = field_q;
        end
        // clock low between rise and fall points on the half step grid
        h1 = pos_d + POS_W'(ratio_q);
        pclk_d[1] = !(run && pos_d >= rise_pt && pos_d < fall_pt);
        pclk_d[0] = !(run && h1 >= rise_pt && h1 < fall_pt);
        if (!run)
            pclk_d = 2'b11;
        act_d[CI_HS] = run && (enc ? (hcnt_d == '0) : (hcnt_d < hsw_q));
        act_d[CI_VS] = run && (vcnt_d < vsw_q || (enc && vcnt_d == '0))
            && !(enc && field_d && vcnt_d == '0 && hcnt_d < (htot_q >> 1));
        in_h = hcnt_d >= hst_q && (hcnt_d - hst_q) < hwd_q;
        in_v = vcnt_d >= vst_q && (vcnt_d - vst_q) < vht_q;
        act_d[CI_DV] = run && in_h && in_v && !(enc && act_d[CI_HS]);
        pix_take = run && pstart && act_d[CI_DV];
        data_d = '0;
        if (pix_take)
            data_d = pix_data;
        else if (act_d[CI_DV])
            data_d = data_q;
    end

    // timing state registers
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            err_q   <= '0;
            pos_q   <= '0;
            hcnt_q  <= '0;
            vcnt_q  <= '0;
            field_q <= 1'b0;
            pclk_q  <= 2'b11;
            act_q   <= '0;
            prev_q  <= '0;
            data_q  <= '0;
        end
        else
        begin
            err_q   <= err_d;
            pos_q   <= pos_d;
            hcnt_q  <= hcnt_d;
            vcnt_q  <= vcnt_d;
            field_q <= field_d;
            pclk_q  <= pclk_d;
            act_q   <= act_d;
            prev_q  <= act_q;
            data_q  <= data_d;
        end
    end

    // polarity and optional half step delay of each control
    assign act_on[CI_HS] = !enc && ctrl_q[CB_HPOL];
    assign act_on[CI_VS] = !enc && ctrl_q[CB_VPOL];
    assign act_on[CI_DV] = enc || ctrl_q[CB_DPOL];
    assign half = {ctrl_q[CB_DHALF], ctrl_q[CB_VHALF], ctrl_q[CB_HHALF]};
    assign hsync_pair  = {half[CI_HS] ? prev_q[CI_HS] : act_q[CI_HS], act_q[CI_HS]}
                         ^ {2{!act_on[CI_HS]}};
    assign vsync_pair  = {half[CI_VS] ? prev_q[CI_VS] : act_q[CI_VS], act_q[CI_VS]}
                         ^ {2{!act_on[CI_VS]}};
    assign dvalid_pair = {half[CI_DV] ? prev_q[CI_DV] : act_q[CI_DV], act_q[CI_DV]}
                         ^ {2{!act_on[CI_DV]}};
    assign pclk_pair   = pclk_q;
    assign data_bus    = data_q;
    assign reg_rdata   = rdata_q;

    // period length helper for checks
    logic [CNT_W-1:0] len_q;
    logic             run_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            len_q <= 12'h001;
            run_q <= 1'b0;
        end
        else
        begin
            len_q <= (!run || pstart) ? 12'h001 : len_q + 1'b1;
            run_q <= run;
        end
    end

    property p_period_len;
        @(posedge clk_sys) disable iff (reset)
        run && run_q && pstart && $stable(div_q) && $stable(ratio_q)
        |-> (int'(len_q) * int'(step) > int'(div_q) - int'(step))
         && (int'(len_q) * int'(step) < int'(div_q) + int'(step));
    endproperty
    a_period_len: assert property (p_period_len) else $error("pixel period length off");
    property p_line_wrap;
        @(posedge clk_sys) disable iff (reset)
        run && pstart && {1'b0, hcnt_q} + 1'b1 == {1'b0, htot_q} ##1 run |-> hcnt_q == '0;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line did not wrap");
    property p_enc_hs_one;
        @(posedge clk_sys) disable iff (reset)
        enc && act_q[CI_HS] |-> hcnt_q == '0;
    endproperty
    a_enc_hs_one: assert property (p_enc_hs_one) else $error("hsync too long");
    property p_enc_dv_hs;
        @(posedge clk_sys) disable iff (reset)
        enc && act_q[CI_DV] |-> !act_q[CI_HS] && hsync_pair == 2'b11;
    endproperty
    a_enc_dv_hs: assert property (p_enc_dv_hs) else $error("data while hsync low");
    property p_enc_pol;
        @(posedge clk_sys) disable iff (reset)
        enc && !half[CI_HS] |-> hsync_pair == {2{!act_q[CI_HS]}};
    endproperty
    a_enc_pol: assert property (p_enc_pol) else $error("hsync polarity wrong");
    property p_data_edge;
        @(posedge clk_sys) disable iff (reset)
        !$stable(data_bus) |-> $past(pstart) || !$past(run);
    endproperty
    a_data_edge: assert property (p_data_edge) else $error("data moved mid period");
    property p_field_edge;
        @(posedge clk_sys) disable iff (reset)
        enc && htot_q > 12'h003 && $rose(act_q[CI_VS]) |-> act_q[CI_HS] == !field_q;
    endproperty
    a_field_edge: assert property (p_field_edge) else $error("field sync pairing");
    property p_dv_gate;
        @(posedge clk_sys) disable iff (reset)
        !act_q[CI_DV] |-> data_bus == '0;
    endproperty
    a_dv_gate: assert property (p_dv_gate) else $error("data without valid");
    property p_vs_edge;
        @(posedge clk_sys) disable iff (reset)
        run && $rose(act_q[CI_VS]) |-> $past(pstart) || !$past(run, 2);
    endproperty
    a_vs_edge: assert property (p_vs_edge) else $error("vsync off pixel edge");
    c_take: cover property (@(posedge clk_sys) disable iff (reset) pix_take);
    c_odd: cover property (@(posedge clk_sys) disable iff (reset)
        enc && $rose(act_q[CI_VS]) && !field_q);
    c_even: cover property (@(posedge clk_sys) disable iff (reset)
        enc && $rose(act_q[CI_VS]) && field_q);
endmodule

// ===== tb/dct_sink_model.sv
// display sink model: follows pixel clock and sync pairs half by half
// assumes each pair carries [1] first half and [0] second half of a base cycle
`timescale 1ns/1ps
module dct_sink_model
(
    input  wire logic       clk_sys,
    input  wire logic [1:0] pclk_pair,
    input  wire logic [1:0] hsync_pair,
    input  wire logic [1:0] vsync_pair,
    output logic            per_stb,
    output logic            line_stb,
    output int              per_halves,
    output int              low_halves,
    output int              line_pix,
    output int              hs_low_pix,
    output int              vs_falls,
    output int              vs_coin
);
    logic pc_l = 1'b1;
    logic hs_l = 1'b1;
    logic vs_l = 1'b1;
    logic hsf;
    int   since = 0;
    int   lowrun = 0;
    int   pix = 0;
    int   hsl = 0;

    // idle outputs before the first edge
    initial
    begin
        {per_stb, line_stb} = 2'h0;
        {per_halves, low_halves, line_pix, hs_low_pix, vs_falls, vs_coin} = '0;
    end

    // walk both halves in time order; pixels counted on clock falls
    always @(posedge clk_sys)
    begin
        per_stb <= 1'b0;
        line_stb <= 1'b0;
        for (int i = 1; i >= 0; i--)
        begin
            hsf = hs_l && !hsync_pair[i];
            since++;
            if (hsf)
            begin
                line_pix <= pix;
                pix = 0;
            end
            if (!hs_l && hsync_pair[i])
            begin
                hs_low_pix <= hsl;
                hsl = 0;
                line_stb <= 1'b1;
            end
            if (vs_l && !vsync_pair[i])
            begin
                vs_falls <= vs_falls + 1;
                vs_coin <= vs_coin + int'(hsf);
            end
            if (pc_l && !pclk_pair[i])
            begin
                per_halves <= since;
                since = 0;
                per_stb <= 1'b1;
                pix++;
                hsl += int'(!hsync_pair[i]);
            end
            if (!pc_l && pclk_pair[i])
                low_halves <= lowrun;
            lowrun = pclk_pair[i] ? 0 : lowrun + 1;
            pc_l = pclk_pair[i];
            hs_l = hsync_pair[i];
            vs_l = vsync_pair[i];
        end
    end
endmodule

// ===== tb/dct_display_timing_test.sv
// bench: drives registers and pixels, models period, line and data timing
// assumes dct_pkg, the design and dct_sink_model are compiled before it
`timescale 1ns/1ps
module dct_display_timing_test
    import dct_pkg::*;
;
    logic              clk_sys, reset, reg_wr, reg_rd, pix_take, pend, chk_on, split_seen;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [PIX_W-1:0]  pix_data, data_bus, exp_byte;
    logic [1:0]        pclk_pair, hsync_pair, vsync_pair, dvalid_pair, dv_on;
    logic              per_stb, line_stb;
    int                per_halves, low_halves, line_pix, hs_low_pix, vs_falls, vs_coin;
    int                fail_count, comparisons, seed, skip, lskip, acc, nper;
    int                fl, ex, elow, n16, ediv, ehtot, ehsw, enc, v0, c0, d;
    int                t_rat[4]  = '{1, 2, 1, 3};
    int                t_div[4]  = '{64, 128, 72, 168};
    int                t_rise[4] = '{1, 1, 0, 1};
    int                t_fall[4] = '{3, 3, 2, 4};

    dct_display_timing dut_u (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .pix_data    (pix_data),
        .pix_take    (pix_take),
        .pclk_pair   (pclk_pair),
        .hsync_pair  (hsync_pair),
        .vsync_pair  (vsync_pair),
        .dvalid_pair (dvalid_pair),
        .data_bus    (data_bus)
    );

    dct_sink_model sink_u (
        .clk_sys    (clk_sys),
        .pclk_pair  (pclk_pair),
        .hsync_pair (hsync_pair),
        .vsync_pair (vsync_pair),
        .per_stb    (per_stb),
        .line_stb   (line_stb),
        .per_halves (per_halves),
        .low_halves (low_halves),
        .line_pix   (line_pix),
        .hs_low_pix (hs_low_pix),
        .vs_falls   (vs_falls),
        .vs_coin    (vs_coin)
    );

    // 250 MHz base clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [DATA_W-1:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one write cycle, then one idle cycle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // a control write moves the model's mode and valid level at its landing edge
        if (a == REG_CTRL)
        begin
            enc <= int'(v[CB_ENC]);
            dv_on <= (v[CB_ENC] || v[CB_DPOL]) ? 2'b11 : 2'b00;
        end
        @(posedge clk_sys);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        rd_val = reg_rdata;
    endtask

    task automatic lines(input logic [CNT_W-1:0] ht, hw, hs, ha, vt, vw, vs, va);
        wr(REG_HTIM, {4'h0, hw, 4'h0, ht});
        wr(REG_HACT, {4'h0, ha, 4'h0, hs});
        wr(REG_VTIM, {4'h0, vw, 4'h0, vt});
        wr(REG_VACT, {4'h0, va, 4'h0, vs});
        ehtot = int'(ht);
        ehsw = int'(hw);
    endtask

    // reprogram while stopped, set the model, run and check status
    task automatic run(input int c, ra, dv, ri, fa, cyc);
        chk_on = 1'b0;
        wr(REG_CTRL, 32'h0);
        wr(REG_RATIO, 32'(ra));
        wr(REG_DIV, 32'(dv));
        wr(REG_EDGE, 32'((fa << 16) | ri));
        fl = dv / (16 * ra);
        ex = int'(dv % (16 * ra) == 0);
        elow = (2 * fa + ra - 1) / ra - (2 * ri + ra - 1) / ra;
        n16 = 16 * ra;
        ediv = dv;
        {acc, nper, skip, lskip} = {32'h0, 32'h0, 32'h3, 32'h2};
        split_seen = 1'b0;
        v0 = vs_falls;
        c0 = vs_coin;
        wr(REG_CTRL, 32'(c));
        chk_on = 1'b1;
        repeat (cyc) @(posedge clk_sys);
        rd(REG_STAT);
        check(32'(rd_val[SB_RUN]), 32'h1, "running");
        if (c[CB_HHALF])
            check(32'(split_seen), 32'h1, "half step");
    endtask

    // pixel source: fresh random component every cycle
    always @(posedge clk_sys)
        pix_data <= PIX_W'($random(seed));

    // model comparisons at every result
    always @(posedge clk_sys)
        if (!reset)
        begin
            if (pend)
            begin
                check(32'(data_bus), 32'(exp_byte), "data byte");
                check(32'(dvalid_pair), 32'(dv_on), "valid level");
            end
            else if (dvalid_pair === ~dv_on)
                check(32'(data_bus), 32'h0, "idle bus");
            if (enc == 1)
                check(32'(dvalid_pair & ~hsync_pair), 32'h0, "valid in sync");
            if (hsync_pair === 2'b10)
                split_seen = 1'b1;
            pend = (pix_take === 1'b1);
            exp_byte = pix_data;
            if (per_stb && chk_on && skip > 0)
                skip--;
            else if (per_stb && chk_on)
            begin
                check(32'(per_halves == 2 * fl || (ex == 0 && per_halves == 2 * fl + 2)),
                      32'h1, "period");
                check(32'(low_halves), 32'(elow), "low phase");
                acc += per_halves;
                nper++;
                if (nper == n16)
                begin
                    check(32'(acc), 32'(2 * ediv), "mean period");
                    {acc, nper} = {32'h0, 32'h0};
                end
            end
            if (line_stb && chk_on && lskip > 0)
                lskip--;
            else if (line_stb && chk_on)
            begin
                check(32'(line_pix), 32'(ehtot), "line length");
                check(32'(hs_low_pix), 32'(ehsw), "sync width");
            end
        end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        {reset, reg_wr, reg_rd, chk_on, pend} = 5'h10;
        {reg_addr, reg_wdata, pix_data, exp_byte, dv_on} = '0;
        {fail_count, comparisons, enc, skip, lskip} = '0;
        seed = 32'hbc13ff10;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(REG_CTRL);
        check(rd_val, 32'(CTRL_RST), "ctrl reset");
        rd(REG_DIV);
        check(rd_val, 32'(DIV_RST), "div reset");
        rd(REG_EDGE);
        check(rd_val, {8'h00, FALL_RST, 8'h00, RISE_RST}, "edge reset");
        rd(REG_HTIM);
        check(rd_val, {4'h0, HSW_RST, 4'h0, HTOT_RST}, "line reset");
        wr(8'h40, 32'hffffffff);
        rd(8'h40);
        check(rd_val, 32'h0, "unmapped");
        // panel mode over integer and fractional divisors
        lines(12'h00c, 12'h002, 12'h004, 12'h006, 12'h005, 12'h001, 12'h001, 12'h003);
        for (int r = 0; r < 4; r++)
            run((r == 0) ? 32'h21 : 32'h01, t_rat[r], t_div[r], t_rise[r], t_fall[r], 800);
        // encoder divisor window edges at unit ratio, period model off
        chk_on = 1'b0;
        wr(REG_RATIO, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            d = (k < 2) ? ENC_DIV_MIN - 1 + k : ENC_DIV_MAX + k - 2;
            wr(REG_CTRL, 32'h0);
            wr(REG_DIV, 32'(d));
            wr(REG_CTRL, 32'h3);
            repeat (20) @(posedge clk_sys);
            rd(REG_STAT);
            check(32'(rd_val[SB_RUN]), 32'(k == 1 || k == 2), "rate window");
        end
        // encoder mode frames with alternating fields
        lines(12'h014, 12'h001, 12'h002, 12'h010, 12'h004, 12'h001, 12'h001, 12'h002);
        run(32'h03, 1, 148, 0, 4, 2400);
        check(32'(vs_coin - c0 > 0 && vs_falls - v0 > vs_coin - c0), 32'h1, "fields");
        report_and_stop();
    end
endmodule
